// >>> verilog/cpu_mode_pkg.sv
// constants, types and register map for the operating-mode controller
package cpu_mode_pkg;

    // register byte offsets on the apb side
    localparam int APB_AW = 8;
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_CSEG = 8'h04;
    localparam logic [7:0] OFF_SMCMD = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;

    // control register fields
    localparam int CTRL_W = 4;
    localparam int CTRL_PROT_BIT = 0;
    localparam int CTRL_LONG_BIT = 1;
    localparam int CTRL_VM16_BIT = 2;
    localparam int CTRL_PAE_BIT = 3;
    localparam logic [3:0] CTRL_RST = 4'h0;

    // code segment descriptor fields
    localparam int CSEG_W = 2;
    localparam int CSEG_LONG_BIT = 0;
    localparam int CSEG_D32_BIT = 1;
    localparam logic [1:0] CSEG_RST = 2'h0;

    // command and status fields
    localparam int SMCMD_RET_BIT = 0;
    localparam int SMCMD_INSMM_BIT = 0;
    localparam int SMCMD_PEND_BIT = 1;
    localparam int ST_MODE_LSB = 0;
    localparam int ST_ASZ_LSB = 4;
    localparam int ST_OSZ_LSB = 6;
    localparam int ST_SEQ_LSB = 8;

    // context store shape and slots
    localparam int CTX_W = 8;
    localparam int CTX_DEPTH = 4;
    localparam int CTX_AW = 2;
    localparam logic [1:0] CTX_CTRL_IDX = 2'h0;
    localparam logic [1:0] CTX_CSEG_IDX = 2'h1;

    // register file shape per mode
    localparam logic [4:0] REGS_LEGACY = 5'h08;
    localparam logic [4:0] REGS_EXT = 5'h10;

    typedef enum logic [2:0] {
        MODE_REAL = 3'b000,
        MODE_PROT = 3'b001,
        MODE_COMPAT = 3'b011,
        MODE_LONG64 = 3'b010,
        MODE_SMM = 3'b110
    } mode_t;

    typedef enum logic [1:0] {
        SZ16 = 2'b00,
        SZ32 = 2'b01,
        SZ64 = 2'b10
    } size_t;

    typedef enum logic [1:0] {
        ACC_B8 = 2'b00,
        ACC_B16 = 2'b01,
        ACC_B32 = 2'b10,
        ACC_B64 = 2'b11
    } acc_t;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b000,
        SEQ_SAVE0 = 3'b001,
        SEQ_SAVE1 = 3'b011,
        SEQ_RUN = 3'b010,
        SEQ_REST0 = 3'b110,
        SEQ_REST1 = 3'b111,
        SEQ_REST2 = 3'b101
    } seq_t;

    // attributes of the instruction now at decode
    typedef struct packed {
        logic boundary;
        logic opsize_ovr;
        logic addrsize_ovr;
        logic rex_w;
        acc_t acc;
    } insn_attr_t;

    // execution environment handed to the core
    typedef struct packed {
        mode_t mode;
        size_t addr_sz;
        size_t op_sz;
        logic [4:0] gpr_count;
        logic [4:0] simd_count;
        logic gpr_width64;
        logic flags_width64;
        logic flags_upper_rsvd;
        logic lin_4g_limit;
        logic phys_ext;
        logic vm16_active;
        logic task_mgmt_ok;
        logic smm_space;
        logic [7:0] lane_mask;
    } mode_info_t;

endpackage

// >>> verilog/ctx_store.sv
// small context memory with registered read data
module ctx_store
    import cpu_mode_pkg::*;
#(
    parameter int W = CTX_W,
    parameter int DEPTH = CTX_DEPTH,
    parameter int AW = CTX_AW
) (
    // clock
    input wire logic pclk,
    // write port
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [W-1:0] wdata,
    // read port
    input wire logic [AW-1:0] raddr,
    output logic [W-1:0] rdata
);

    logic [W-1:0] mem [DEPTH];

    // no reset: contents only meaningful after a save
    always_ff @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata <= mem[raddr];
    end

endmodule

// >>> verilog/cpu_mode_ctrl.sv
// operating-mode controller: mode select, system management entry and return, sizes
// Notes on behaviour
// [RQ1] three base modes gate available features
// [RQ2] reset always lands in real-address mode
// [RQ3] pin or controller message enters management
// [RQ4] entry saves context, selects private space
// [RQ5] return restores exactly the saved state
// [RQ6] 16-bit emulation is protected-mode task attribute
// [RQ7] compat: 4 GByte linear, extension keeps physical
// [RQ8] compat: only 16/32-bit address and operand
// [RQ9] compat: no emulation, no hardware task switch
// [RQ10] segment long bit picks compat or 64
// [RQ11] 64-bit: sixteen wide registers of each kind
// [RQ12] 64-bit: default address 64, operand 32
// [RQ13] extension prefix with override selects operand size
// [RQ14] 32-bit registers also reachable as 8/16
// [RQ15] byte access low 8 bits, flags 64
// [RQ16] management request taken only at boundaries
//
// Our own choices: the address map and the APB slave port.
module cpu_mode_ctrl
    import cpu_mode_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // management requests
    input wire logic sys_mgmt_request_pin_n,
    input wire logic programmable_irq_controller_smi,
    // decode side
    input wire insn_attr_t insn,
    output mode_info_t info
);

    logic [CTRL_W-1:0] ctrl_reg;
    logic [CSEG_W-1:0] cseg_reg;
    seq_t seq_reg;
    logic pend_reg;
    logic pin_s1_reg, pin_s2_reg, pin_hist_reg;
    logic [CTX_W-1:0] ctx_rdata;
    logic ctx_we;
    logic [CTX_AW-1:0] ctx_waddr, ctx_raddr;
    logic [CTX_W-1:0] ctx_wdata;
    logic in_smm, take, pin_event, wr_fire, ctrl_wr_ok, ret_fire;
    logic acc_phase, err_next;
    logic [31:0] rdata_next;
    mode_t mode_cur;
    mode_info_t info_next;

    // which register an address picks, 0 for none
    function automatic logic [2:0] reg_sel(input logic [APB_AW-1:0] a);
        if (a == OFF_CTRL) begin
            return 3'h1;
        end else if (a == OFF_CSEG) begin
            return 3'h2;
        end else if (a == OFF_SMCMD) begin
            return 3'h3;
        end else if (a == OFF_STATUS) begin
            return 3'h4;
        end else begin
            return 3'h0;
        end
    endfunction

    // legacy size override flips between 16 and 32
    function automatic size_t flip_sz(input size_t s, input logic ovr);
        if (!ovr) begin
            return s;
        end
        return (s == SZ16) ? SZ32 : SZ16;
    endfunction

    // byte lanes of a register touched by one access
    function automatic logic [7:0] lanes(input acc_t a, input logic wide);
        case (a)
            ACC_B8: return 8'h01; // [RQ15]
            ACC_B16: return 8'h03; // [RQ14]
            ACC_B32: return 8'h0F; // [RQ14]
            default: return wide ? 8'hFF : 8'h0F;
        endcase
    endfunction

    // request pin crosses in through two flops before any use
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_reg <= 1'b1;
            pin_s2_reg <= 1'b1;
            pin_hist_reg <= 1'b1;
        end else begin
            pin_s1_reg <= sys_mgmt_request_pin_n;
            pin_s2_reg <= pin_s1_reg;
            pin_hist_reg <= pin_s2_reg;
        end
    end

    assign pin_event = pin_hist_reg & ~pin_s2_reg;
    assign in_smm = (seq_reg == SEQ_RUN) || (seq_reg == SEQ_REST0) ||
                    (seq_reg == SEQ_REST1) || (seq_reg == SEQ_REST2);
    // only a completed instruction may be interrupted
    assign take = pend_reg & insn.boundary & (seq_reg == SEQ_IDLE); // [RQ16]

    // pending flag: a fresh request beats the take in the same cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pend_reg <= 1'b0;
        end else if (pin_event || programmable_irq_controller_smi) begin
            pend_reg <= 1'b1; // [RQ3]
        end else if (take) begin
            pend_reg <= 1'b0;
        end
    end

    // apb handshake: one wait state, answer prepared in the first access cycle
    assign acc_phase = psel & penable & ~pready;
    assign wr_fire = psel & penable & pready & pwrite & ~pslverr;
    assign ctrl_wr_ok = ((seq_reg == SEQ_IDLE) && !take) || (seq_reg == SEQ_RUN);
    assign ret_fire = wr_fire && (reg_sel(paddr) == 3'h3) && pwdata[SMCMD_RET_BIT];

    // error answer: unmapped, status write, blocked while saving or restoring, stray return
    always_comb begin
        err_next = 1'b0;
        if (reg_sel(paddr) == 3'h0) begin
            err_next = 1'b1;
        end else if (pwrite && (reg_sel(paddr) == 3'h1 || reg_sel(paddr) == 3'h2)) begin
            err_next = ~ctrl_wr_ok;
        end else if (pwrite && reg_sel(paddr) == 3'h3) begin
            err_next = pwdata[SMCMD_RET_BIT] & (seq_reg != SEQ_RUN);
        end else if (pwrite && reg_sel(paddr) == 3'h4) begin
            err_next = 1'b1;
        end
    end

    // read mux
    always_comb begin
        rdata_next = 32'h0000_0000;
        if (reg_sel(paddr) == 3'h1) begin
            rdata_next[CTRL_W-1:0] = ctrl_reg;
        end else if (reg_sel(paddr) == 3'h2) begin
            rdata_next[CSEG_W-1:0] = cseg_reg;
        end else if (reg_sel(paddr) == 3'h3) begin
            rdata_next[SMCMD_INSMM_BIT] = in_smm;
            rdata_next[SMCMD_PEND_BIT] = pend_reg;
        end else if (reg_sel(paddr) == 3'h4) begin
            rdata_next[ST_MODE_LSB +: 3] = info.mode;
            rdata_next[ST_ASZ_LSB +: 2] = info.addr_sz;
            rdata_next[ST_OSZ_LSB +: 2] = info.op_sz;
            rdata_next[ST_SEQ_LSB +: 3] = seq_reg;
        end
    end

    // apb answer registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= acc_phase;
            pslverr <= acc_phase & err_next;
            prdata <= (acc_phase && !pwrite && !err_next) ? rdata_next : 32'h0000_0000;
        end
    end

    // entry and return sequencer around the context store
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seq_reg <= SEQ_IDLE;
        end else begin
            case (seq_reg)
                SEQ_IDLE: if (take) seq_reg <= SEQ_SAVE0; // [RQ3]
                SEQ_SAVE0: seq_reg <= SEQ_SAVE1; // [RQ4]
                SEQ_SAVE1: seq_reg <= SEQ_RUN; // [RQ4]
                SEQ_RUN: if (ret_fire) seq_reg <= SEQ_REST0; // [RQ5]
                SEQ_REST0: seq_reg <= SEQ_REST1;
                SEQ_REST1: seq_reg <= SEQ_REST2;
                default: seq_reg <= SEQ_IDLE;
            endcase
        end
    end

    // save both words on entry, read them back in order on return
    always_comb begin
        ctx_we = (seq_reg == SEQ_SAVE0) || (seq_reg == SEQ_SAVE1); // [RQ4]
        ctx_waddr = (seq_reg == SEQ_SAVE0) ? CTX_CTRL_IDX : CTX_CSEG_IDX;
        ctx_wdata = '0;
        if (seq_reg == SEQ_SAVE0) begin
            ctx_wdata[CTRL_W-1:0] = ctrl_reg;
        end else begin
            ctx_wdata[CSEG_W-1:0] = cseg_reg;
        end
        ctx_raddr = (seq_reg == SEQ_REST0) ? CTX_CTRL_IDX : CTX_CSEG_IDX;
    end

    ctx_store #(.W(CTX_W), .DEPTH(CTX_DEPTH), .AW(CTX_AW)) u_ctx (
        .pclk(pclk),
        .we(ctx_we),
        .waddr(ctx_waddr),
        .wdata(ctx_wdata),
        .raddr(ctx_raddr),
        .rdata(ctx_rdata)
    );

    // control register: restore beats software, handler starts from clean state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_reg <= CTRL_RST; // [RQ2]
        end else if (seq_reg == SEQ_REST1) begin
            ctrl_reg <= ctx_rdata[CTRL_W-1:0]; // [RQ5]
        end else if (seq_reg == SEQ_SAVE1) begin
            ctrl_reg <= CTRL_RST;
        end else if (wr_fire && reg_sel(paddr) == 3'h1) begin
            ctrl_reg <= pwdata[CTRL_W-1:0];
        end
    end

    // code segment attributes, loaded by software per segment
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cseg_reg <= CSEG_RST;
        end else if (seq_reg == SEQ_REST2) begin
            cseg_reg <= ctx_rdata[CSEG_W-1:0]; // [RQ5]
        end else if (seq_reg == SEQ_SAVE1) begin
            cseg_reg <= CSEG_RST;
        end else if (wr_fire && reg_sel(paddr) == 3'h2) begin
            cseg_reg <= pwdata[CSEG_W-1:0]; // [RQ10]
        end
    end

    // current mode from control bits and the executing segment
    always_comb begin
        if (in_smm) begin
            mode_cur = MODE_SMM; // [RQ1]
        end else if (!ctrl_reg[CTRL_PROT_BIT]) begin
            mode_cur = MODE_REAL; // [RQ2]
        end else if (!ctrl_reg[CTRL_LONG_BIT]) begin
            mode_cur = MODE_PROT;
        end else if (cseg_reg[CSEG_LONG_BIT]) begin
            mode_cur = MODE_LONG64; // [RQ10]
        end else begin
            mode_cur = MODE_COMPAT; // [RQ10]
        end
    end

    // environment for the instruction at decode
    always_comb begin
        logic wide;
        size_t base;
        wide = (mode_cur == MODE_LONG64);
        base = cseg_reg[CSEG_D32_BIT] ? SZ32 : SZ16;
        if (mode_cur == MODE_REAL || mode_cur == MODE_SMM) begin
            base = SZ16;
        end
        info_next.mode = mode_cur;
        if (wide) begin
            info_next.addr_sz = insn.addrsize_ovr ? SZ32 : SZ64; // [RQ12]
            if (insn.rex_w) begin
                info_next.op_sz = SZ64; // [RQ13]
            end else begin
                info_next.op_sz = insn.opsize_ovr ? SZ16 : SZ32; // [RQ12]
            end
        end else begin
            info_next.addr_sz = flip_sz(base, insn.addrsize_ovr); // [RQ8]
            info_next.op_sz = flip_sz(base, insn.opsize_ovr); // [RQ8]
        end
        info_next.gpr_count = wide ? REGS_EXT : REGS_LEGACY; // [RQ11]
        info_next.simd_count = wide ? REGS_EXT : REGS_LEGACY; // [RQ11]
        info_next.gpr_width64 = wide; // [RQ11]
        info_next.flags_width64 = wide; // [RQ15]
        info_next.flags_upper_rsvd = wide; // [RQ15]
        info_next.lin_4g_limit = (mode_cur != MODE_LONG64); // [RQ7]
        info_next.phys_ext = ctrl_reg[CTRL_PAE_BIT] &&
                             (mode_cur == MODE_PROT || mode_cur == MODE_COMPAT ||
                              mode_cur == MODE_LONG64); // [RQ7]
        // emulation and task switching live only in plain protected mode
        info_next.vm16_active = ctrl_reg[CTRL_VM16_BIT] && (mode_cur == MODE_PROT); // [RQ6]
        info_next.task_mgmt_ok = (mode_cur == MODE_PROT); // [RQ9]
        info_next.smm_space = in_smm; // [RQ4]
        info_next.lane_mask = lanes(insn.acc, wide); // [RQ14]
    end

    // registered environment, real-address mode out of reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            info <= '{mode: MODE_REAL, addr_sz: SZ16, op_sz: SZ16, gpr_count: REGS_LEGACY,
                      simd_count: REGS_LEGACY, lane_mask: 8'h01, default: 1'b0}; // [RQ2]
        end else begin
            info <= info_next;
        end
    end

    // helper state for the checks below
    logic first_reg;
    logic [CTRL_W-1:0] chk_ctrl_reg;
    logic [CSEG_W-1:0] chk_cseg_reg;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            first_reg <= 1'b1;
            chk_ctrl_reg <= CTRL_RST;
            chk_cseg_reg <= CSEG_RST;
        end else begin
            first_reg <= 1'b0;
            if (seq_reg == SEQ_SAVE0) begin
                chk_ctrl_reg <= ctrl_reg;
                chk_cseg_reg <= cseg_reg;
            end
        end
    end

    a_reset_real_mode: assert property (@(posedge pclk) disable iff (!presetn) // [RQ2]
        first_reg |-> (info.mode == MODE_REAL && mode_cur == MODE_REAL))
        else $error("not in real-address mode after reset");
    a_entry_on_req: assert property (@(posedge pclk) disable iff (!presetn) // [RQ3]
        (pend_reg && insn.boundary && seq_reg == SEQ_IDLE) |=> seq_reg == SEQ_SAVE0 ##3
        info.smm_space)
        else $error("pending request not taken into management mode");
    a_take_at_boundary: assert property (@(posedge pclk) disable iff (!presetn) // [RQ16]
        (seq_reg == SEQ_SAVE0) |-> $past(insn.boundary) && $past(seq_reg) == SEQ_IDLE)
        else $error("management request taken off a boundary");
    a_save_then_space: assert property (@(posedge pclk) disable iff (!presetn) // [RQ4]
        (seq_reg == SEQ_SAVE0) |-> ctx_we ##1 ctx_we ##1 (seq_reg == SEQ_RUN) ##1
        (info.smm_space && info.mode == MODE_SMM))
        else $error("context save or space switch out of order");
    a_restore_exact: assert property (@(posedge pclk) disable iff (!presetn) // [RQ5]
        ($past(seq_reg) == SEQ_REST2) |-> (ctrl_reg == chk_ctrl_reg &&
        cseg_reg == chk_cseg_reg && seq_reg == SEQ_IDLE))
        else $error("state after return differs from state at entry");
    a_vm16_prot_only: assert property (@(posedge pclk) disable iff (!presetn) // [RQ6]
        info.vm16_active |-> info.mode == MODE_PROT)
        else $error("16-bit emulation outside protected mode");
    a_compat_limits: assert property (@(posedge pclk) disable iff (!presetn) // [RQ9]
        (info.mode == MODE_COMPAT) |-> (info.lin_4g_limit && !info.vm16_active &&
        !info.task_mgmt_ok && info.addr_sz != SZ64 && info.op_sz != SZ64))
        else $error("compatibility mode limits broken");
    a_long_defaults: assert property (@(posedge pclk) disable iff (!presetn) // [RQ12]
        (mode_cur == MODE_LONG64 && !insn.opsize_ovr && !insn.addrsize_ovr &&
        !insn.rex_w) |=> (info.addr_sz == SZ64 && info.op_sz == SZ32))
        else $error("wrong default sizes in 64-bit mode");
    a_rex_wide_op: assert property (@(posedge pclk) disable iff (!presetn) // [RQ13]
        (mode_cur == MODE_LONG64 && insn.rex_w) |=> info.op_sz == SZ64)
        else $error("extension prefix did not give 64-bit operand");
    a_long_regfile: assert property (@(posedge pclk) disable iff (!presetn) // [RQ11]
        (info.mode == MODE_LONG64) |-> (info.gpr_count == REGS_EXT &&
        info.simd_count == REGS_EXT && info.gpr_width64 && info.flags_upper_rsvd))
        else $error("64-bit register file not exposed");
    a_byte_low_lane: assert property (@(posedge pclk) disable iff (!presetn) // [RQ15]
        (insn.acc == ACC_B8) |=> info.lane_mask == 8'h01)
        else $error("byte access not on lowest lane");

endmodule

// >>> tb/smi_source.sv
// partner model: management request pin and controller message source
module smi_source (
    // clock
    input wire logic pclk,
    // request lines toward the core
    output logic pin_n,
    output logic msg
);
    timeunit 1ns;
    timeprecision 100ps;

    // pin idles high as if pulled up, message line idles low
    initial begin
        pin_n = 1'b1;
        msg = 1'b0;
    end

    // one-cycle message from the interrupt controller
    task pulse_msg();
        @(posedge pclk);
        msg <= 1'b1;
        @(posedge pclk);
        msg <= 1'b0;
    endtask

    // pin held low a few cycles so the synchroniser sees the edge
    task pull_pin();
        @(posedge pclk);
        pin_n <= 1'b0;
        repeat (4) @(posedge pclk);
        pin_n <= 1'b1;
    endtask
endmodule

// >>> tb/cpu_mode_ctrl_tb.sv
// self-checking bench for the operating-mode controller
module cpu_mode_ctrl_tb;
    import cpu_mode_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;

    // clock, reset and bus
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    // requests and decode side
    logic pin_n;
    logic msg;
    insn_attr_t insn;
    mode_info_t info;
    // bookkeeping
    int n_mismatch;
    int cmp_count;
    logic [31:0] rd;
    logic er;

    cpu_mode_ctrl u_cpu_mode_ctrl (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .sys_mgmt_request_pin_n(pin_n),
        .programmable_irq_controller_smi(msg), .insn(insn), .info(info)
    );

    smi_source u_smi_source (.pclk(pclk), .pin_n(pin_n), .msg(msg));

    // 250 MHz core clock
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // one apb transfer; a dead slave is caught by the watchdog, not here
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [7:0] a, input logic [31:0] d, input logic exp_err);
        apb(1'b1, a, d);
        chk("pslverr", er, exp_err);
    endtask

    task rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk("rdata", rd, exp);
    endtask

    task settle();
        repeat (2) @(posedge pclk);
    endtask

    task wait_mode(input mode_t m);
        int n;
        n = 0;
        while (info.mode !== m && n < 30) begin
            @(posedge pclk);
            n++;
        end
        chk("mode", info.mode, m);
    endtask

    task summarize();
        $display("checks %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // watchdog far beyond the hundred-odd cycles the tests need
    initial begin
        #100000;
        n_mismatch++;
        summarize();
    end

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        insn = '0;
        presetn = 1'b0;
        n_mismatch = 0;
        cmp_count = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        insn <= 6'h20;
        settle();
        // power-up shape
        chk("mode", info.mode, MODE_REAL);
        chk("gpr", info.gpr_count, REGS_LEGACY);
        // protected mode with the emulation task attribute
        wr(OFF_CTRL, 32'h5, 1'b0);
        settle();
        chk("mode", info.mode, MODE_PROT);
        chk("vm16", info.vm16_active, 1'b1);
        // compatibility: emulation bit set yet must stay off
        wr(OFF_CTRL, 32'hF, 1'b0);
        wr(OFF_CSEG, 32'h2, 1'b0);
        settle();
        chk("mode", info.mode, MODE_COMPAT);
        chk("asz", info.addr_sz, SZ32);
        chk("osz", info.op_sz, SZ32);
        chk("lin4g", info.lin_4g_limit, 1'b1);
        chk("physx", info.phys_ext, 1'b1);
        chk("vm16", info.vm16_active, 1'b0);
        chk("taskm", info.task_mgmt_ok, 1'b0);
        // 64-bit segment
        wr(OFF_CSEG, 32'h3, 1'b0);
        settle();
        chk("mode", info.mode, MODE_LONG64);
        chk("asz", info.addr_sz, SZ64);
        chk("osz", info.op_sz, SZ32);
        chk("gpr", info.gpr_count, REGS_EXT);
        chk("simd", info.simd_count, REGS_EXT);
        chk("gpr64", info.gpr_width64, 1'b1);
        chk("flags", {info.flags_width64, info.flags_upper_rsvd}, 2'b11);
        chk("lanes", info.lane_mask, 8'h01);
        // byte lanes per access width, address override
        insn <= 6'h23;
        settle();
        chk("lanes", info.lane_mask, 8'hFF);
        insn <= 6'h21;
        settle();
        chk("lanes", info.lane_mask, 8'h03);
        insn <= 6'h28;
        settle();
        chk("asz", info.addr_sz, SZ32);
        // per-instruction operand overrides
        insn <= 6'h24;
        settle();
        chk("osz", info.op_sz, SZ64);
        insn <= 6'h30;
        settle();
        chk("osz", info.op_sz, SZ16);
        rdc(OFF_STATUS, 32'h22);
        // refused accesses
        wr(OFF_STATUS, 32'h0, 1'b1);
        apb(1'b0, 8'h10, 32'h0);
        chk("pslverr", er, 1'b1);
        wr(OFF_SMCMD, 32'h1, 1'b1);
        // request held off while not at an instruction boundary
        insn <= 6'h00;
        u_smi_source.pulse_msg();
        repeat (8) @(posedge pclk);
        chk("mode", info.mode, MODE_LONG64);
        rdc(OFF_SMCMD, 32'h2);
        insn <= 6'h20;
        wait_mode(MODE_SMM);
        chk("space", info.smm_space, 1'b1);
        rdc(OFF_CTRL, 32'h0);
        rdc(OFF_SMCMD, 32'h1);
        // return restores the interrupted state
        wr(OFF_SMCMD, 32'h1, 1'b0);
        wait_mode(MODE_LONG64);
        chk("space", info.smm_space, 1'b0);
        rdc(OFF_CTRL, 32'hF);
        rdc(OFF_CSEG, 32'h3);
        // pin path
        u_smi_source.pull_pin();
        wait_mode(MODE_SMM);
        wr(OFF_SMCMD, 32'h1, 1'b0);
        wait_mode(MODE_LONG64);
        // reset in mid-run drops back to real mode
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        settle();
        chk("mode", info.mode, MODE_REAL);
        rdc(OFF_CTRL, 32'h0);
        summarize();
    end
endmodule
